// file: rtl/tcc_pkg.sv
package tcc_pkg;

	// Register placement in the expanded bank
	localparam logic [3:0] CTRL_OFFSET = 4'h1;
	localparam logic [7:0] CTRL_RESET  = 8'h00;

	// Field positions
	localparam int MODE_BIT     = 7;
	localparam int ROUTE_BIT    = 6;
	localparam int LOGIC_HI     = 5;
	localparam int LOGIC_LO     = 4;
	localparam int SEQ_HI       = 3;
	localparam int SEQ_LO       = 2;
	localparam int SHORT_LVL_BIT = 1;
	localparam int LONG_LVL_BIT  = 0;

	// Field reset values
	localparam logic       MODE_RESET  = 1'h0;
	localparam logic       ROUTE_RESET = 1'h0;
	localparam logic [1:0] LOGIC_RESET = 2'h0;
	localparam logic [1:0] SEQ_RESET   = 2'h0;
	localparam logic       LVL_RESET   = 1'h0;

	// Combining logic codes (transmit)
	localparam logic [1:0] LOGIC_AND  = 2'h0;
	localparam logic [1:0] LOGIC_OR   = 2'h1;
	localparam logic [1:0] LOGIC_NOR  = 2'h2;
	localparam logic [1:0] LOGIC_NAND = 2'h3;

	// Sequencing codes (transmit)
	localparam logic [1:0] SEQ_NORMAL = 2'h0;
	localparam logic [1:0] SEQ_PING   = 2'h1;
	localparam logic [1:0] SEQ_FORCE0 = 2'h2;
	localparam logic [1:0] SEQ_FORCE1 = 2'h3;

	// Edge select codes (demodulation)
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h2;

	// Glitch filter codes and lengths in system clocks
	localparam logic [1:0] FILT_NONE  = 2'h0;
	localparam logic [1:0] FILT_SHORT = 2'h1;
	localparam logic [1:0] FILT_LONG  = 2'h2;
	localparam logic [3:0] FILT_SHORT_CYC = 4'h4;
	localparam logic [3:0] FILT_LONG_CYC  = 4'h8;

endpackage

// file: rtl/tcc_filter_if.sv
`timescale 1ns/1ps
interface tcc_filter_if;
	logic       raw;
	logic [1:0] filt_sel;
	logic [1:0] edge_sel;
	logic       level;
	logic       rise;
	logic       fall;

	modport ctrl (
		output raw,
		output filt_sel,
		output edge_sel,
		input  level,
		input  rise,
		input  fall
	);

	modport filt (
		input  raw,
		input  filt_sel,
		input  edge_sel,
		output level,
		output rise,
		output fall
	);
endinterface

// file: rtl/tcc_edge_filter.sv
`timescale 1ns/1ps
module tcc_edge_filter (
	// Clock and reset
	input wire logic      mclk_i,
	input wire logic      nrst_i,
	// Filter link
	tcc_filter_if.filt    fif
);

	logic [3:0] run_len;
	logic [3:0] need;
	logic       primed;
	logic       level;
	logic       take;

	always_comb begin
		unique case (fif.filt_sel)
			tcc_pkg::FILT_SHORT: need = tcc_pkg::FILT_SHORT_CYC;
			tcc_pkg::FILT_LONG:  need = tcc_pkg::FILT_LONG_CYC;
			default:             need = 4'h0;
		endcase
	end

	// New level accepted once it has held for the filter length
	assign take = (fif.raw != level) &&
		((need == 4'h0) || (run_len + 4'h1 >= need));

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			run_len <= 4'h0;
		end else if (fif.raw == level || take) begin
			run_len <= 4'h0;
		end else begin
			run_len <= run_len + 4'h1;
		end
	end

	// First cycle adopts the pin level so reset gives no false edge
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			primed <= 1'b0;
			level  <= 1'b0;
		end else if (!primed) begin
			primed <= 1'b1;
			level  <= fif.raw;
		end else if (take) begin
			level <= fif.raw;
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fif.rise <= 1'b0;
			fif.fall <= 1'b0;
		end else begin
			fif.rise <= primed && take && fif.raw &&
				(fif.edge_sel == tcc_pkg::EDGE_RISE ||
				 fif.edge_sel == tcc_pkg::EDGE_BOTH);
			fif.fall <= primed && take && !fif.raw &&
				(fif.edge_sel == tcc_pkg::EDGE_FALL ||
				 fif.edge_sel == tcc_pkg::EDGE_BOTH);
		end
	end

	assign fif.level = level;

endmodule

// file: rtl/tcc_common_control.sv
`timescale 1ns/1ps
// Summary of operation
// - Bit 7 picks transmit (0) or demodulation (1); rest follows it.
// - Reset gives transmit, normal sequencing, port output, levels 0.
// - Transmit: routing bit 1 drives port3_pin6 from combined output.
// - Demodulation: routing bit picks port3_pin1 (0) or port2_pin0 (1).
// - Transmit logic field: AND, OR, NOR, NAND of both counter outputs.
// - Logic field resets to AND; stop-mode recovery leaves it alone.
// - Demodulation edge field: falling, rising, both; code 11 reserved.
// - Transmit sequence field: normal, ping-pong, force long out 0/1.
// - Demodulation filter field: none, 4 clocks, 8 clocks; 11 reserved.
// - Transmit bit 1 sets short counter output initial level.
// - Transmit bit 0 sets long counter output initial level.
// - Demodulation bit 1 reads rising-edge flag; write 1 clears it.
// - Demodulation bit 0 reads falling-edge flag; write 1 clears it.
// - Sequence and filter field sit in bits 3 and 2.
// - Logic and edge field sit in bits 5 and 4.
// - Short counter level and rising flag sit in bit 1.
// - Long counter level and falling flag sit in bit 0.
module tcc_common_control (
	// Clock and resets
	input  wire logic       mclk_i,
	input  wire logic       nrst_i,
	input  wire logic       smr_i,
	// Expanded register file access
	input  wire logic       bank_sel_i,
	input  wire logic [3:0] addr_i,
	input  wire logic       wr_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] rdata_o,
	// Counter outputs to combine
	input  wire logic       short_counter_output_i,
	input  wire logic       long_counter_output_i,
	// Pins
	input  wire logic       port3_pin6_data_i,
	input  wire logic       port3_pin1_i,
	input  wire logic       port2_pin0_i,
	output logic            port3_pin6_o,
	// Status towards the counters
	output logic            demod_mode_o,
	output logic            ping_pong_o,
	output logic            short_init_level_o,
	output logic            long_init_level_o,
	output logic            long_out_force_o,
	output logic            long_out_force_val_o,
	output logic            demod_level_o,
	output logic            demod_edge_o
);

	logic       mode;
	logic       route;
	logic [1:0] logic_sel;
	logic [1:0] seq_sel;
	logic       short_lvl;
	logic       long_lvl;
	logic       rise_flag;
	logic       fall_flag;
	logic       hit_wr;
	logic       long_eff;
	logic       combined;
	logic [7:0] ctrl_view;

	tcc_filter_if fif ();

	////////////////////////////////////////////////////////////////////////
	// Register writes

	function automatic logic ctrl_hit(input logic sel, input logic [3:0] a);
		return sel && (a == tcc_pkg::CTRL_OFFSET);
	endfunction

	assign hit_wr = wr_i && ctrl_hit(bank_sel_i, addr_i);

	// Recovery resets all but the logic field
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mode    <= tcc_pkg::MODE_RESET;
			route   <= tcc_pkg::ROUTE_RESET;
			seq_sel <= tcc_pkg::SEQ_RESET;
		end else if (smr_i) begin
			mode    <= tcc_pkg::MODE_RESET;
			route   <= tcc_pkg::ROUTE_RESET;
			seq_sel <= tcc_pkg::SEQ_RESET;
		end else if (hit_wr) begin
			mode    <= wdata_i[tcc_pkg::MODE_BIT];
			route   <= wdata_i[tcc_pkg::ROUTE_BIT];
			seq_sel <= wdata_i[tcc_pkg::SEQ_HI:tcc_pkg::SEQ_LO];
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			logic_sel <= tcc_pkg::LOGIC_RESET;
		end else if (hit_wr) begin
			logic_sel <= wdata_i[tcc_pkg::LOGIC_HI:tcc_pkg::LOGIC_LO];
		end
	end

	// Initial levels are only written in transmit mode
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			short_lvl <= tcc_pkg::LVL_RESET;
			long_lvl  <= tcc_pkg::LVL_RESET;
		end else if (smr_i) begin
			short_lvl <= tcc_pkg::LVL_RESET;
			long_lvl  <= tcc_pkg::LVL_RESET;
		end else if (hit_wr && !mode) begin
			short_lvl <= wdata_i[tcc_pkg::SHORT_LVL_BIT];
			long_lvl  <= wdata_i[tcc_pkg::LONG_LVL_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Edge flags; a new edge beats a same-cycle clear

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rise_flag <= 1'b0;
		end else if (mode && fif.rise) begin
			rise_flag <= 1'b1;
		end else if (smr_i) begin
			rise_flag <= 1'b0;
		end else if (hit_wr && mode && wdata_i[tcc_pkg::SHORT_LVL_BIT]) begin
			rise_flag <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fall_flag <= 1'b0;
		end else if (mode && fif.fall) begin
			fall_flag <= 1'b1;
		end else if (smr_i) begin
			fall_flag <= 1'b0;
		end else if (hit_wr && mode && wdata_i[tcc_pkg::LONG_LVL_BIT]) begin
			fall_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Demodulator input path

	// Reserved codes pass through as no filter and no edge
	assign fif.raw      = route ? port2_pin0_i : port3_pin1_i;
	assign fif.filt_sel = mode ? seq_sel : tcc_pkg::FILT_NONE;
	assign fif.edge_sel = mode ? logic_sel : 2'h3;

	tcc_edge_filter u_filter (
		.mclk_i (mclk_i),
		.nrst_i (nrst_i),
		.fif    (fif)
	);

	////////////////////////////////////////////////////////////////////////
	// Transmit output path

	always_comb begin
		unique case (seq_sel)
			tcc_pkg::SEQ_FORCE0: long_eff = 1'b0;
			tcc_pkg::SEQ_FORCE1: long_eff = 1'b1;
			default:             long_eff = long_counter_output_i;
		endcase
	end

	always_comb begin
		unique case (logic_sel)
			tcc_pkg::LOGIC_AND:  combined = short_counter_output_i & long_eff;
			tcc_pkg::LOGIC_OR:   combined = short_counter_output_i | long_eff;
			tcc_pkg::LOGIC_NOR:  combined = ~(short_counter_output_i | long_eff);
			tcc_pkg::LOGIC_NAND: combined = ~(short_counter_output_i & long_eff);
		endcase
	end

	// Pin registered; demod mode leaves it as a port output
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			port3_pin6_o <= 1'b0;
		end else if (!mode && route) begin
			port3_pin6_o <= combined;
		end else begin
			port3_pin6_o <= port3_pin6_data_i;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read back and status

	// Bits 1:0 mean levels or flags depending on mode
	assign ctrl_view = {mode, route, logic_sel, seq_sel,
		mode ? rise_flag : short_lvl,
		mode ? fall_flag : long_lvl};

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o <= 8'h00;
		end else if (ctrl_hit(bank_sel_i, addr_i)) begin
			rdata_o <= ctrl_view;
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// Mode change while counting is software's concern, not guarded here
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			demod_mode_o         <= 1'b0;
			ping_pong_o          <= 1'b0;
			short_init_level_o   <= 1'b0;
			long_init_level_o    <= 1'b0;
			long_out_force_o     <= 1'b0;
			long_out_force_val_o <= 1'b0;
			demod_level_o        <= 1'b0;
			demod_edge_o         <= 1'b0;
		end else begin
			demod_mode_o         <= mode;
			ping_pong_o          <= !mode && seq_sel == tcc_pkg::SEQ_PING;
			short_init_level_o   <= short_lvl;
			long_init_level_o    <= long_lvl;
			long_out_force_o     <= !mode && seq_sel[1];
			long_out_force_val_o <= seq_sel[0];
			demod_level_o        <= fif.level;
			demod_edge_o         <= mode && (fif.rise || fif.fall);
		end
	end

endmodule

// file: testbench/tcc_common_control_properties.sv
`timescale 1ns/1ps
module tcc_common_control_properties (
	input wire logic       mclk_i,
	input wire logic       nrst_i,
	input wire logic       smr_i,
	input wire logic       bank_sel_i,
	input wire logic [3:0] addr_i,
	input wire logic       wr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] rdata_o,
	input wire logic       short_counter_output_i,
	input wire logic       long_counter_output_i,
	input wire logic       port3_pin6_data_i,
	input wire logic       port3_pin1_i,
	input wire logic       port2_pin0_i,
	input wire logic       port3_pin6_o,
	input wire logic       demod_mode_o,
	input wire logic       ping_pong_o,
	input wire logic       short_init_level_o,
	input wire logic       long_init_level_o,
	input wire logic       long_out_force_o,
	input wire logic       long_out_force_val_o,
	input wire logic       demod_level_o,
	input wire logic       demod_edge_o
);
	logic [7:0] s;
	logic [1:0] age;
	logic       hit;
	logic       raw;
	logic       pexp;

	function automatic logic mix(logic [7:0] c, logic a, logic b);
		logic bb;
		bb = c[3] ? c[2] : b;
		case (c[5:4])
			2'h0: mix = a & bb;
			2'h1: mix = a | bb;
			2'h2: mix = !(a | bb);
			default: mix = !(a & bb);
		endcase
	endfunction

	assign hit = wr_i && bank_sel_i && addr_i == 4'h1;
	assign raw = s[6] ? port2_pin0_i : port3_pin1_i;
	assign pexp = (!s[6] || s[7]) ? port3_pin6_data_i
		: mix(s, short_counter_output_i, long_counter_output_i);

	// Outputs lag the register by one edge, so skip the first three
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i)
			age <= 2'h0;
		else if (age != 2'h3)
			age <= age + 2'h1;
	end

	// Shadow of the register; levels only stored in transmit
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i)
			s <= 8'h00;
		else if (smr_i)
			s <= {2'h0, hit ? wdata_i[5:4] : s[5:4], 4'h0};
		else if (hit)
			s <= {wdata_i[7:2], s[7] ? s[1:0] : wdata_i[1:0]};
	end

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	a_mode_copy: assert property (
		age == 2'h3 |-> demod_mode_o == $past(s[7]))
		else $error("mode output wrong");
	a_ping_pong: assert property (
		age == 2'h3 |-> ping_pong_o == $past(!s[7] && s[3:2] == 2'h1))
		else $error("ping-pong output wrong");
	a_force_long: assert property (
		age == 2'h3 |-> long_out_force_o == $past(!s[7] && s[3]))
		else $error("force output wrong");
	a_init_levels: assert property (
		age == 2'h3 |->
		{short_init_level_o, long_init_level_o} == $past(s[1:0]))
		else $error("initial levels wrong");
	a_pin_combine: assert property (
		age == 2'h3 |-> port3_pin6_o == $past(pexp))
		else $error("pin level wrong");
	a_read_view: assert property (
		age == 2'h3 && $past(bank_sel_i && addr_i == 4'h1) |->
		rdata_o[7:2] == $past(s[7:2]) &&
		($past(s[7]) || rdata_o[1:0] == $past(s[1:0])))
		else $error("read view wrong");
	a_read_unmapped: assert property (
		age == 2'h3 && !$past(bank_sel_i && addr_i == 4'h1) |->
		rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_filter_hold: assert property (
		s[7] && s[3:2] == 2'h2 && $past(s[3:2], 8) == 2'h2 &&
		$past(s[7], 8) && demod_level_o != $past(demod_level_o) |->
		$past(raw, 3) == demod_level_o && $past(raw, 6) == demod_level_o)
		else $error("short pulse passed filter");
	a_force_value: assert property (
		age == 2'h3 |-> long_out_force_val_o == $past(s[2]))
		else $error("force value wrong");
	// Edge pulse only with a level change of the selected polarity
	a_edge_pulse: assert property (
		age == 2'h3 && demod_edge_o |-> demod_mode_o &&
		demod_level_o != $past(demod_level_o) &&
		($past(s[5:4], 2) == 2'h2 ||
		 $past(s[5:4], 2) == {1'b0, demod_level_o}))
		else $error("edge pulse wrong");
endmodule

// file: testbench/tcc_pulse_src.sv
`timescale 1ns/1ps
module tcc_pulse_src (
	// Clock
	input  wire logic mclk_i,
	// Line choice and level
	input  wire logic sel_i,
	input  wire logic level_i,
	// Pins
	output logic      port3_pin1_o,
	output logic      port2_pin0_o
);
	logic noise = 1'b0;

	// Unselected pin toggles so a wrong route shows up as edges
	always @(posedge mclk_i)
		noise <= !noise;
	assign port3_pin1_o = sel_i ? noise : level_i;
	assign port2_pin0_o = sel_i ? level_i : noise;
endmodule

// file: testbench/timer_common_control_test.sv
`timescale 1ns/1ps
module timer_common_control_test;
	logic        mclk_i, nrst_i, smr_i, bank_sel_i, wr_i;
	logic [3:0]  addr_i;
	logic [7:0]  wdata_i, rdata_o, c, c2, x, obs;
	logic        sc, lc, pd, sel, lvl, p31, p20, pin, dm, pp, si, li, fo;
	logic [15:0] r;
	int          num_errors, num_checks, n, w;

	tcc_common_control tcc_common_control_i (
		.mclk_i(mclk_i), .nrst_i(nrst_i), .smr_i(smr_i),
		.bank_sel_i(bank_sel_i), .addr_i(addr_i), .wr_i(wr_i),
		.wdata_i(wdata_i), .rdata_o(rdata_o),
		.short_counter_output_i(sc), .long_counter_output_i(lc),
		.port3_pin6_data_i(pd), .port3_pin1_i(p31), .port2_pin0_i(p20),
		.port3_pin6_o(pin), .demod_mode_o(dm), .ping_pong_o(pp),
		.short_init_level_o(si), .long_init_level_o(li),
		.long_out_force_o(fo), .long_out_force_val_o(),
		.demod_level_o(), .demod_edge_o());
	tcc_pulse_src tcc_pulse_src_i (.mclk_i(mclk_i), .sel_i(sel),
		.level_i(lvl), .port3_pin1_o(p31), .port2_pin0_o(p20));
	assign obs = {2'h0, si, li, pin, pp, fo, dm};

	////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr(logic [15:0] v);
		lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic logic [3:0] tx(logic [7:0] k, logic a, b, d);
		logic bb, y;
		bb = k[3] ? k[2] : b;
		case (k[5:4])
			2'h0: y = a & bb;
			2'h1: y = a | bb;
			2'h2: y = !(a | bb);
			default: y = !(a & bb);
		endcase
		tx = {k[6] ? y : d, k[3:2] == 2'h1, k[3], 1'b0};
	endfunction
	function automatic logic [1:0] flags(logic [1:0] e);
		flags = {e == 2'h1 || e == 2'h2, e == 2'h0 || e == 2'h2};
	endfunction

	task end_sim;
		$display("Checks %0d, errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: saw %h, wanted %h", $time, got, exp);
		end
	endtask
	task tick(input int k);
		repeat (k) @(posedge mclk_i);
		#1;
	endtask
	task wr(input logic [7:0] d);
		tick(1);
		{wr_i, bank_sel_i, addr_i, wdata_i} = {2'h3, 4'h1, d};
		tick(1);
		{wr_i, bank_sel_i} = 2'h0;
	endtask
	task rd(input logic b, input logic [3:0] a, input logic [7:0] e);
		tick(1);
		{bank_sel_i, addr_i} = {b, a};
		tick(1);
		bank_sel_i = 1'b0;
		chk(rdata_o, e);
	endtask
	task pulse(input int k);
		tick(1);
		lvl = 1'b0;
		tick(k);
		lvl = 1'b1;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end
	initial begin
		#200000;
		num_errors++;
		end_sim;
	end
	initial begin
		{nrst_i, smr_i, bank_sel_i, wr_i, addr_i, wdata_i} = 16'h0000;
		{sc, lc, pd, sel, lvl} = 5'h01;
		{num_errors, num_checks} = 0;
		r = 16'h2D50;
		tick(2);
		nrst_i = 1'b1;
		rd(1'b1, 4'h1, 8'h00);
		chk(obs, 8'h00);
		// Counters feed random levels; codes walk all four values
		for (n = 0; n < 64; n++) begin
			r = lfsr(r);
			c = {1'b0, r[6], n[1:0], n[3:2], r[1:0]};
			wr(c);
			{sc, lc, pd} = r[10:8];
			x = {2'h0, c[1:0], tx(c, r[10], r[9], r[8])};
			tick(1);
			chk(obs, x);
			addr_i = r[11] ? 4'h1 : r[15:12];
			c2 = (r[7] && addr_i == 4'h1) ? c : 8'h00;
			rd(r[7], addr_i, c2);
		end
		wr(8'h7F);
		smr_i = 1'b1;
		tick(1);
		smr_i = 1'b0;
		rd(1'b1, 4'h1, 8'h30);
		// Levels zeroed before the mode flips, counters idle
		wr(8'h00);
		wr(8'h80);
		for (n = 0; n < 16; n++) begin
			c = {1'b1, n[0], n[3:2], n[1:0], 2'h0};
			w = c[3:2] == 2'h1 ? 4 : c[3:2] == 2'h2 ? 8 : 0;
			wr(c | 8'h03);
			sel = c[6];
			tick(12);
			wr(c | 8'h03);
			rd(1'b1, 4'h1, c);
			if (w > 0) begin
				pulse(w - 1);
				tick(12);
				rd(1'b1, 4'h1, c);
			end
			pulse(w + 3);
			tick(w + 12);
			c2 = c | {6'h00, flags(c[5:4])};
			rd(1'b1, 4'h1, c2);
			wr(c);
			rd(1'b1, 4'h1, c2);
			wr(c | 8'h03);
			rd(1'b1, 4'h1, c);
		end
		// Edge in the cycle of a clearing write keeps the flag
		wr(8'h80);
		sel = 1'b0;
		tick(1);
		lvl = 1'b0;
		wr(8'h83);
		rd(1'b1, 4'h1, 8'h81);
		end_sim;
	end
endmodule

bind tcc_common_control tcc_common_control_properties
	tcc_common_control_properties_i (
	.mclk_i(mclk_i), .nrst_i(nrst_i), .smr_i(smr_i),
	.bank_sel_i(bank_sel_i), .addr_i(addr_i), .wr_i(wr_i),
	.wdata_i(wdata_i), .rdata_o(rdata_o),
	.short_counter_output_i(short_counter_output_i),
	.long_counter_output_i(long_counter_output_i),
	.port3_pin6_data_i(port3_pin6_data_i),
	.port3_pin1_i(port3_pin1_i), .port2_pin0_i(port2_pin0_i),
	.port3_pin6_o(port3_pin6_o), .demod_mode_o(demod_mode_o),
	.ping_pong_o(ping_pong_o),
	.short_init_level_o(short_init_level_o),
	.long_init_level_o(long_init_level_o),
	.long_out_force_o(long_out_force_o),
	.long_out_force_val_o(long_out_force_val_o),
	.demod_level_o(demod_level_o), .demod_edge_o(demod_edge_o));
